// ---- cdt_regs.vh ----
`ifndef CDT_REGS_VH
`define CDT_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define CDT_LOAD_OFS 12'h400
`define CDT_VALUE_OFS 12'h404
`define CDT_CTRL_OFS 12'h408
`define CDT_CLEAR_OFS 12'h40C
`define CDT_RAW_OFS 12'h410
`define CDT_MASKED_OFS 12'h414
`define CDT_RELOAD_OFS 12'h418
`define CDT_PREDIV_OFS 12'h41C
`define CDT_FREE_OFS 12'h420
`define CDT_EVSTAT_OFS 12'h424
`define CDT_EVMASK_OFS 12'h428

// ****************************************
// Control fields and reset values
// ****************************************
`define CDT_CTRL_RESET 32'h003E0020
`define CDT_CTRL_WMASK 32'h00FF03FF
`define CDT_CTRL_WIDE 1
`define CDT_CTRL_PSC_LO 2
`define CDT_CTRL_PSC_HI 3
`define CDT_CTRL_IRQEN 5
`define CDT_CTRL_TEN 7
`define CDT_CTRL_DBGSTOP 8
`define CDT_CTRL_FREN 9
`define CDT_CTRL_FRPSC_LO 16
`define CDT_CTRL_FRPSC_HI 23
`define CDT_PREDIV_RESET 10'h07D
`define CDT_PSC_DIV16 2'h1
`define CDT_PSC_DIV256 2'h2
`define CDT_NARROW_MASK 32'h0000FFFF

// ****************************************
// Bus responses and event bits
// ****************************************
`define CDT_RESP_OKAY 2'h0
`define CDT_RESP_SLVERR 2'h2
`define CDT_EV_EXPIRE 0
`define CDT_EV_FRWRAP 1

`endif

// ---- cdt_timer.v ----
`timescale 1ns/1ps
`include "cdt_regs.vh"

module cdt_timer
#(
	// Arbitrary signature value
	parameter [31:0] SIGNATURE = 32'h5A5A0001
)
(
	input wire core_clk,
	input wire nrst,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire debugHalt,
	output reg timerIrq,
	output reg eventIrq
);

	// ****************************************
	// Helpers
	// ****************************************
	function mapped;
		input [11:0] addr;
		begin
			mapped = (addr[1:0] == 2'h0) && (addr >= `CDT_LOAD_OFS) &&
				(addr <= `CDT_EVMASK_OFS);
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	// Count limited to the selected width
	function [31:0] fit;
		input [31:0] v;
		input wide;
		begin
			fit = wide ? v : (v & `CDT_NARROW_MASK);
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	reg awHeld;
	reg wHeld;
	reg [11:0] wAddr;
	reg [31:0] wData;
	reg [3:0] wStrb;
	reg [31:0] ctrl;
	reg [31:0] loadVal;
	reg [31:0] count;
	reg [9:0] preDiv;
	reg [9:0] preCnt;
	reg [7:0] scaleCnt;
	reg [7:0] frDivCnt;
	reg [31:0] freeCnt;
	reg pending;
	reg [1:0] evStat;
	reg [1:0] evMask;

	wire doWrite;
	wire running;
	wire tick;
	wire [1:0] psc;
	reg scaledTick;
	wire timerStep;
	wire expire;
	wire frStep;
	wire frWrap;
	wire wrLoad;
	wire wrReload;
	wire wrClear;
	wire [31:0] newData;
	wire wideSel;
	wire [31:0] preDivMerged;

	assign doWrite = awHeld && wHeld && !s_axi_bvalid;
	assign running = !(ctrl[`CDT_CTRL_DBGSTOP] && debugHalt);
	// pre-divider tick
	// At or above, so a lowered divider never waits for a wrap
	assign tick = running && (preCnt >= preDiv);
	assign psc = ctrl[`CDT_CTRL_PSC_HI:`CDT_CTRL_PSC_LO];
	assign wideSel = ctrl[`CDT_CTRL_WIDE];

	always @*
	begin
		case (psc)
			`CDT_PSC_DIV16: scaledTick = tick && (scaleCnt[3:0] == 4'hF);
			`CDT_PSC_DIV256: scaledTick = tick && (scaleCnt == 8'hFF);
			// codes 00 and 11 divide by one
			default: scaledTick = tick;
		endcase
	end

	assign timerStep = scaledTick && ctrl[`CDT_CTRL_TEN];
	assign expire = timerStep && (fit(count, wideSel) == 32'h00000000);
	assign frStep = running && ctrl[`CDT_CTRL_FREN] &&
		(frDivCnt >= ctrl[`CDT_CTRL_FRPSC_HI:`CDT_CTRL_FRPSC_LO]);
	assign frWrap = frStep && (freeCnt == 32'hFFFFFFFF);
	assign wrLoad = doWrite && (wAddr == `CDT_LOAD_OFS);
	assign wrReload = doWrite && (wAddr == `CDT_RELOAD_OFS);
	assign wrClear = doWrite && (wAddr == `CDT_CLEAR_OFS);
	assign newData = merge(loadVal, wData, wStrb);
	assign preDivMerged = merge({22'h000000, preDiv}, wData, wStrb);

	// ****************************************
	// Write channel
	// ****************************************
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wAddr <= 12'h000;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CDT_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld <= 1'b1;
				wAddr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (doWrite)
			begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(wAddr) ? `CDT_RESP_OKAY :
					`CDT_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ****************************************
	// Registers and counters
	// ****************************************
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl <= `CDT_CTRL_RESET;
			loadVal <= 32'h00000000;
			count <= 32'h00000000;
			preDiv <= `CDT_PREDIV_RESET;
			preCnt <= 10'h000;
			scaleCnt <= 8'h00;
			frDivCnt <= 8'h00;
			freeCnt <= 32'h00000000;
			pending <= 1'b0;
			evStat <= 2'h0;
			evMask <= 2'h0;
			timerIrq <= 1'b0;
			eventIrq <= 1'b0;
		end
		else
		begin
			if (running)
				preCnt <= tick ? 10'h000 : preCnt + 10'h001;
			if (tick)
				scaleCnt <= scaleCnt + 8'h01;
			if (running && ctrl[`CDT_CTRL_FREN])
				frDivCnt <= frStep ? 8'h00 : frDivCnt + 8'h01;
			if (frStep)
				freeCnt <= freeCnt + 32'h00000001;
			if (wrLoad)
				count <= fit(newData, wideSel);
			else if (expire)
				count <= fit(loadVal, wideSel);
			else if (timerStep)
				count <= fit(count - 32'h00000001, wideSel);
			if (wrLoad || wrReload)
				loadVal <= fit(newData, wideSel);
			if (expire)
				pending <= 1'b1;
			else if (wrClear)
				pending <= 1'b0;
			// bits 9:0 and 23:16 only stored
			if (doWrite && wAddr == `CDT_CTRL_OFS)
				ctrl <= merge(ctrl, wData, wStrb) & `CDT_CTRL_WMASK;
			if (doWrite && wAddr == `CDT_PREDIV_OFS)
				preDiv <= preDivMerged[9:0];
			if (doWrite && wAddr == `CDT_EVMASK_OFS)
				evMask <= wData[1:0];
			if (doWrite && wAddr == `CDT_EVSTAT_OFS)
				evStat <= (evStat & ~wData[1:0]) | {frWrap, expire};
			else
				evStat <= evStat | {frWrap, expire};
			timerIrq <= pending && ctrl[`CDT_CTRL_IRQEN];
			eventIrq <= |(evStat & evMask);
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `CDT_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(s_axi_araddr) ? `CDT_RESP_OKAY :
				`CDT_RESP_SLVERR;
			case (s_axi_araddr)
				`CDT_LOAD_OFS: s_axi_rdata <= loadVal;
				`CDT_VALUE_OFS: s_axi_rdata <= fit(count, wideSel);
				`CDT_CTRL_OFS: s_axi_rdata <= ctrl;
				`CDT_CLEAR_OFS: s_axi_rdata <= SIGNATURE;
				`CDT_RAW_OFS: s_axi_rdata <= {31'h00000000, pending};
				`CDT_MASKED_OFS: s_axi_rdata <= {31'h00000000,
					pending && ctrl[`CDT_CTRL_IRQEN]};
				`CDT_RELOAD_OFS: s_axi_rdata <= loadVal;
				`CDT_PREDIV_OFS: s_axi_rdata <= {22'h000000, preDiv};
				`CDT_FREE_OFS: s_axi_rdata <= freeCnt;
				`CDT_EVSTAT_OFS: s_axi_rdata <= {30'h00000000, evStat};
				`CDT_EVMASK_OFS: s_axi_rdata <= {30'h00000000, evMask};
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// ---- cdt_timer_props.sv ----
`timescale 1ns/1ps
`include "cdt_regs.vh"
module cdt_timer_props
#(
	parameter [31:0] SIGNATURE = 32'h5A5A0001
)
(
	input logic core_clk,
	input logic nrst,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [11:0] s_axi_araddr,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic timerIrq
);
default clocking @(posedge core_clk); endclocking
default disable iff (!nrst);
logic rdTake;
logic [11:0] ra;
assign rdTake = s_axi_arvalid && s_axi_arready;
assign ra = s_axi_araddr;
a_write_answer: assert property (s_axi_awvalid && s_axi_awready
	&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
	else $error("no bvalid");
a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
	else $error("bvalid dropped");
a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
	else $error("awready stayed high");
a_read_answer: assert property (rdTake |=> s_axi_rvalid && !s_axi_arready)
	else $error("no rvalid");
a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
	else $error("rvalid dropped");
a_sig_read:
	assert property (rdTake && ra == `CDT_CLEAR_OFS |=> s_axi_rdata == SIGNATURE)
		else $error("bad signature");
a_raw_upper:
	assert property (rdTake && ra == `CDT_RAW_OFS |=> s_axi_rdata[31:1] == 0)
		else $error("raw upper bits set");
a_masked_upper:
	assert property (rdTake && ra == `CDT_MASKED_OFS |=> s_axi_rdata[31:1] == 0)
		else $error("masked upper bits set");
a_unmapped_err: assert property (rdTake && ra == 12'h000
	|=> s_axi_rresp == `CDT_RESP_SLVERR && s_axi_rdata == 0)
	else $error("no error");
c_sig: cover property (rdTake && ra == `CDT_CLEAR_OFS);
c_write: cover property (s_axi_bvalid && s_axi_bready);
c_irq: cover property ($rose(timerIrq));
endmodule
bind cdt_timer cdt_timer_props #(.SIGNATURE(SIGNATURE)) u_props (
	.core_clk(core_clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.timerIrq(timerIrq));

// ---- tb.sv ----
`timescale 1ns/1ps
`include "cdt_regs.vh"
module tb;
logic core_clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0;
logic arvalid = 0, rready = 0, debugHalt = 0;
logic [11:0] awaddr = 0, araddr = 0;
logic [31:0] wdata = 0, rnd = 67;
logic [3:0] wstrb = 4'hF;
logic awready, wready, bvalid, arready, rvalid, timerIrq, eventIrq;
logic [1:0] bresp, rresp;
logic [31:0] rdata;
logic [31:0] expQ[$];
int miscompares = 0, testsRun = 0, cyc = 0;
cdt_timer u_dut (.core_clk(core_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
	.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
	.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
	.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
	.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
	.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
	.s_axi_rready(rready), .debugHalt(debugHalt), .timerIrq(timerIrq),
	.eventIrq(eventIrq));
always #10 core_clk = ~core_clk;
// ****************************************
// Checks and bus tasks
// ****************************************
task chk(input logic [31:0] s, input logic [31:0] e);
	testsRun++;
	if (s !== e)
	begin
		miscompares++;
		$display("wrong value at %0t: seen %h expected %h", $time, s, e);
	end
endtask
task closeOut;
	$display("checks %0d mismatches %0d", testsRun, miscompares);
	if (miscompares == 0 && testsRun > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
endtask
function logic [31:0] xs(input logic [31:0] v);
	v ^= v << 13;
	v ^= v >> 17;
	return v ^ (v << 5);
endfunction
task wr(input logic [11:0] a, input logic [31:0] d);
	@(posedge core_clk);
	awaddr <= a;
	wdata <= d;
	awvalid <= 1;
	wvalid <= 1;
	bready <= 1;
	fork
		begin
			do @(posedge core_clk); while (!awready);
			awvalid <= 0;
		end
		begin
			do @(posedge core_clk); while (!wready);
			wvalid <= 0;
		end
	join
	while (!bvalid) @(posedge core_clk);
	bready <= 0;
endtask
task rd(input logic [11:0] a, input logic [31:0] e);
	expQ.push_back(e);
	@(posedge core_clk);
	araddr <= a;
	arvalid <= 1;
	rready <= 1;
	do @(posedge core_clk); while (!arready);
	arvalid <= 0;
	do @(posedge core_clk); while (!rvalid);
	rready <= 0;
endtask
task waitIrq;
	for (int i = 0; i < 100 && timerIrq !== 1; i++) @(posedge core_clk);
endtask
// Lets the halted counters run for exactly n clock edges
task run(input int n);
	debugHalt <= 0;
	repeat (n) @(posedge core_clk);
	debugHalt <= 1;
endtask
always @(posedge core_clk)
begin
	if (rvalid && rready)
		chk(rdata, expQ.pop_front());
	if (bvalid && bready)
		chk(bresp, `CDT_RESP_OKAY);
	cyc <= cyc + 1;
	if (cyc == 20000)
	begin
		miscompares++;
		closeOut;
	end
end
// ****************************************
// Main sequence
// ****************************************
initial
begin
	repeat (6) @(posedge core_clk);
	nrst <= 1;
	rd(`CDT_CTRL_OFS, 32'h003E0020);
	rd(`CDT_PREDIV_OFS, 32'h0000007D);
	rd(`CDT_CLEAR_OFS, 32'h5A5A0001);
	rd(12'h000, 32'h00000000);
	rd(`CDT_FREE_OFS, 32'h00000000);
	wr(`CDT_PREDIV_OFS, 32'h00000000);
	wr(`CDT_LOAD_OFS, 32'h00000005);
	wr(`CDT_RELOAD_OFS, 32'h00000002);
	rd(`CDT_VALUE_OFS, 32'h00000005);
	wr(`CDT_EVMASK_OFS, 32'h00000001);
	rnd = xs(rnd);
	wr(`CDT_CTRL_OFS, 32'h000000A0 | (rnd & 32'h00000041));
	waitIrq;
	chk(timerIrq, 1);
	chk(eventIrq, 1);
	wr(`CDT_CTRL_OFS, 32'h00000020);
	rd(`CDT_RAW_OFS, 32'h00000001);
	rd(`CDT_MASKED_OFS, 32'h00000001);
	rd(`CDT_LOAD_OFS, 32'h00000002);
	wr(`CDT_CTRL_OFS, 32'h00000000);
	wr(`CDT_EVMASK_OFS, 32'h00000000);
	repeat (2) @(posedge core_clk);
	chk(timerIrq, 0);
	chk(eventIrq, 0);
	rd(`CDT_MASKED_OFS, 32'h00000000);
	rd(`CDT_CLEAR_OFS, 32'h5A5A0001);
	rd(`CDT_RAW_OFS, 32'h00000001);
	rnd = xs(rnd);
	wr(`CDT_CLEAR_OFS, rnd);
	wr(`CDT_EVSTAT_OFS, 32'h00000003);
	rd(`CDT_RAW_OFS, 32'h00000000);
	debugHalt <= 1;
	wr(`CDT_LOAD_OFS, 32'h00000003);
	rd(`CDT_VALUE_OFS, 32'h00000003);
	wr(`CDT_CTRL_OFS, 32'h000001A0);
	repeat (20) @(posedge core_clk);
	rd(`CDT_VALUE_OFS, 32'h00000003);
	rd(`CDT_RAW_OFS, 32'h00000000);
	debugHalt <= 0;
	waitIrq;
	chk(timerIrq, 1);
	repeat (4) @(posedge core_clk);
	// ****************************************
	// Rates counted in halt windows
	// ****************************************
	debugHalt <= 1;
	wr(`CDT_CTRL_OFS, 32'h00030300);
	run(8);
	rd(`CDT_FREE_OFS, 32'h00000002);
	run(4);
	rd(`CDT_FREE_OFS, 32'h00000003);
	wr(`CDT_CTRL_OFS, 32'h00000184);
	wr(`CDT_LOAD_OFS, 32'h00000064);
	run(32);
	rd(`CDT_VALUE_OFS, 32'h00000062);
	wr(`CDT_CTRL_OFS, 32'h00000188);
	wr(`CDT_LOAD_OFS, 32'h00000064);
	run(256);
	rd(`CDT_VALUE_OFS, 32'h00000063);
	wr(`CDT_CTRL_OFS, 32'h0000018C);
	wr(`CDT_LOAD_OFS, 32'h00000064);
	run(5);
	rd(`CDT_VALUE_OFS, 32'h0000005F);
	wr(`CDT_PREDIV_OFS, 32'h00000003);
	wr(`CDT_CTRL_OFS, 32'h00000180);
	wr(`CDT_LOAD_OFS, 32'h00000064);
	run(8);
	rd(`CDT_VALUE_OFS, 32'h00000062);
	wr(`CDT_CTRL_OFS, 32'h00000182);
	wr(`CDT_LOAD_OFS, 32'h00012345);
	rd(`CDT_VALUE_OFS, 32'h00012345);
	wstrb <= 4'h1;
	wr(`CDT_LOAD_OFS, 32'hFFFFFF77);
	wstrb <= 4'hF;
	rd(`CDT_VALUE_OFS, 32'h00012377);
	wr(`CDT_CTRL_OFS, 32'h00000180);
	wr(`CDT_LOAD_OFS, 32'h00012345);
	rd(`CDT_VALUE_OFS, 32'h00002345);
	closeOut;
end
endmodule
